// [lepc_energy_assertions.sv]
// Port checks for the line energy power control block.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/100ps

module lepc_energy_assertions #(
  parameter int unsigned IDLE_CYCLES = 80,
  parameter int unsigned PULSE_GAP = 2
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Watched ports.
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic data_event_i,
  input wire logic line_energy_i,
  input wire logic power_up_o,
  input wire logic pulse_o,
  input wire logic diag_page_open_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // Each check ties an output to its cause; reset edges are masked.
  a_state_mirror: assert property (
    reg_rd_i && reg_addr_i == 5'h1d |=> reg_rdata_o[10] == $past(power_up_o))
    else $error("state bit differs");
  a_page_open: assert property (
    reg_wr_i && reg_addr_i == 5'h13 |=>
    diag_page_open_o == ($past(reg_wdata_i[1]) && !$past(reg_wdata_i[0])))
    else $error("page window wrong");
  a_pulse_follow: assert property ($rose(power_up_o) ##1 power_up_o |-> pulse_o)
    else $error("no pulse after wake");
  a_pulse_while_up: assert property (pulse_o |-> power_up_o)
    else $error("pulse while asleep");
  a_pulse_gap: assert property (pulse_o |=> !pulse_o)
    else $error("pulse too long");
  a_manual_toggle: assert property (
    reg_wr_i && reg_addr_i == 5'h1d && reg_wdata_i[15] && reg_wdata_i[12]
    |=> power_up_o != $past(power_up_o))
    else $error("manual write did not toggle");
  a_manual_clear: assert property (
    reg_rd_i && reg_addr_i == 5'h1d |=> !reg_rdata_o[12])
    else $error("manual bit not self-cleared");
  a_fall_cause: assert property (
    $fell(power_up_o) |-> !$past(line_energy_i) || $past(reg_wr_i))
    else $error("sleep without cause");
  a_wake_cause: assert property (
    $rose(power_up_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2) || $past(data_event_i, 2))
    else $error("wake without cause");
endmodule // lepc_energy_assertions

bind lepc_line_energy_power_control lepc_energy_assertions #(
  .IDLE_CYCLES(IDLE_CYCLES), .PULSE_GAP(PULSE_GAP)) chk_u (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .data_event_i(data_event_i), .line_energy_i(line_energy_i), .power_up_o(power_up_o),
  .pulse_o(pulse_o), .diag_page_open_o(diag_page_open_o));

// [lepc_line_energy_power_control.sv]
// Energy-detect power management for one transceiver port.
// Assumes event inputs are one-cycle pulses synchronous to clk_sys_i and
// that the register port issues at most one read or write per cycle.
`timescale 1ns/100ps

module lepc_line_energy_power_control #(
  parameter int unsigned IDLE_CYCLES = 32'(lepc_pkg::LEPC_IDLE_CYCLES),
  parameter int unsigned PULSE_GAP = 2
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Configuration strap, sampled during reset.
  input wire logic strap_energy_en_i,
  // Register port.
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // Line side.
  input wire logic data_event_i,
  input wire logic error_event_i,
  input wire logic line_energy_i,
  output logic power_up_o,
  output logic pulse_o,
  // Page control.
  output logic diag_page_open_o
);

  typedef enum logic {LEPC_ST_DOWN, LEPC_ST_UP} lepc_state_t;

  lepc_pkg::lepc_ctrl_t ctrl_reg;
  lepc_pkg::lepc_req_t req;
  lepc_state_t state_reg;
  lepc_state_t state_next;
  logic [1:0] page_reg;
  logic [4:0] data_cnt_reg;
  logic [4:0] err_cnt_reg;
  logic [31:0] idle_cnt_reg;
  logic idle_expired;
  logic data_hit_reg;
  logic err_hit_reg;
  logic [2:0] pulses_left_reg;
  logic [31:0] gap_cnt_reg;
  logic pulse_reg;
  logic [15:0] rdata_reg;
  logic wr_watch;
  logic rd_watch;
  logic manual_toggle;
  logic [15:0] watch_view;

  // Count that saturates at its top value rather than wrapping back to zero.
  function automatic logic [4:0] lepc_sat_inc(input logic [4:0] v);
    lepc_sat_inc = (v == 5'h1f) ? v : v + 5'h01;
  endfunction

  // Threshold test shared by the data and error counters.
  function automatic logic lepc_met(input logic [4:0] cnt, input logic [3:0] thr);
    lepc_met = (cnt >= {1'b0, thr});
  endfunction

  // Decode of the register port.
  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
  assign wr_watch = req.wr && (req.addr == lepc_pkg::LEPC_ADDR_ENERGY_WATCH);
  assign rd_watch = req.rd && (req.addr == lepc_pkg::LEPC_ADDR_ENERGY_WATCH);
  assign manual_toggle = wr_watch && req.wdata[lepc_pkg::LEPC_BIT_MANUAL];
  assign idle_expired = (idle_cnt_reg >= IDLE_CYCLES - 1);

  // Writable control fields; enable reloads from strap during reset.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg.energy_watch_enable <= strap_energy_en_i;
      ctrl_reg.auto_wake_enable <= lepc_pkg::LEPC_RST_AUTO_WAKE;
      ctrl_reg.auto_sleep_enable <= lepc_pkg::LEPC_RST_AUTO_SLEEP;
      ctrl_reg.pulse_burst_disable <= lepc_pkg::LEPC_RST_BURST_DIS;
      ctrl_reg.error_event_threshold <= lepc_pkg::LEPC_RST_ERR_THR;
      ctrl_reg.data_event_threshold <= lepc_pkg::LEPC_RST_DATA_THR;
    end
    else if (wr_watch)
    begin
      ctrl_reg.energy_watch_enable <= req.wdata[lepc_pkg::LEPC_BIT_ENABLE];
      ctrl_reg.auto_wake_enable <= req.wdata[lepc_pkg::LEPC_BIT_AUTO_WAKE];
      ctrl_reg.auto_sleep_enable <= req.wdata[lepc_pkg::LEPC_BIT_AUTO_SLEEP];
      ctrl_reg.pulse_burst_disable <= req.wdata[lepc_pkg::LEPC_BIT_BURST_DIS];
      ctrl_reg.error_event_threshold <=
        req.wdata[lepc_pkg::LEPC_ERR_THR_MSB:lepc_pkg::LEPC_ERR_THR_LSB];
      ctrl_reg.data_event_threshold <=
        req.wdata[lepc_pkg::LEPC_DATA_THR_MSB:lepc_pkg::LEPC_DATA_THR_LSB];
    end
  end

  // Page select register; only the diagnostics code opens the page.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      page_reg <= lepc_pkg::LEPC_RST_PAGE;
    end
    else if (req.wr && (req.addr == lepc_pkg::LEPC_ADDR_PAGE_SELECT))
    begin
      page_reg <= req.wdata[1:0];
    end
  end

  assign diag_page_open_o = (page_reg == lepc_pkg::LEPC_PAGE_DIAG);

  // Idle timer: runs between data events, so noise bursts cannot pile up
  // across long quiet gaps.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || data_event_i || idle_expired)
    begin
      idle_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
    end
  end

  // Event counters; they also restart on every power state change so each
  // new state counts afresh.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || idle_expired || (state_next != state_reg))
    begin
      data_cnt_reg <= 5'h00;
      err_cnt_reg <= 5'h00;
    end
    else
    begin
      if (data_event_i)
      begin
        data_cnt_reg <= lepc_sat_inc(data_cnt_reg);
      end
      if (error_event_i)
      begin
        err_cnt_reg <= lepc_sat_inc(err_cnt_reg);
      end
    end
  end

  // Sticky threshold flags; a new hit in the read cycle wins over the clear.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      data_hit_reg <= 1'b0;
      err_hit_reg <= 1'b0;
    end
    else
    begin
      if (lepc_met(data_cnt_reg, ctrl_reg.data_event_threshold))
      begin
        data_hit_reg <= 1'b1;
      end
      else if (rd_watch)
      begin
        data_hit_reg <= 1'b0;
      end
      if (lepc_met(err_cnt_reg, ctrl_reg.error_event_threshold))
      begin
        err_hit_reg <= 1'b1;
      end
      else if (rd_watch)
      begin
        err_hit_reg <= 1'b0;
      end
    end
  end

  // Power state decision. The error flag deliberately drives nothing here.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      LEPC_ST_DOWN:
      begin
        if (!ctrl_reg.energy_watch_enable)
        begin
          state_next = LEPC_ST_UP;
        end
        else if (manual_toggle)
        begin
          state_next = LEPC_ST_UP;
        end
        else if (ctrl_reg.auto_wake_enable &&
                 lepc_met(data_cnt_reg, ctrl_reg.data_event_threshold))
        begin
          state_next = LEPC_ST_UP;
        end
      end
      LEPC_ST_UP:
      begin
        if (!ctrl_reg.energy_watch_enable)
        begin
          state_next = LEPC_ST_UP;
        end
        else if (manual_toggle)
        begin
          state_next = LEPC_ST_DOWN;
        end
        else if (ctrl_reg.auto_sleep_enable && !line_energy_i)
        begin
          state_next = LEPC_ST_DOWN;
        end
      end
      default:
      begin
        state_next = LEPC_ST_UP;
      end
    endcase
  end

  // Power state register; out of reset the transceiver is powered.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= LEPC_ST_UP;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign power_up_o = (state_reg == LEPC_ST_UP);

  // Pulse burst at each driver power-up, spaced PULSE_GAP cycles apart.
  // A power-down mid-burst abandons the rest of the burst.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pulses_left_reg <= 3'h0;
      gap_cnt_reg <= 32'h0000_0000;
      pulse_reg <= 1'b0;
    end
    else if ((state_reg == LEPC_ST_DOWN) && (state_next == LEPC_ST_UP))
    begin
      pulses_left_reg <= ctrl_reg.pulse_burst_disable ?
                         lepc_pkg::LEPC_BURST_SHORT : lepc_pkg::LEPC_BURST_LONG;
      gap_cnt_reg <= 32'h0000_0000;
      pulse_reg <= 1'b0;
    end
    else if ((state_reg == LEPC_ST_UP) && (state_next == LEPC_ST_UP) && (pulses_left_reg != 3'h0))
    begin
      if (gap_cnt_reg == 32'h0000_0000)
      begin
        pulse_reg <= 1'b1;
        pulses_left_reg <= pulses_left_reg - 3'h1;
        gap_cnt_reg <= PULSE_GAP - 1;
      end
      else
      begin
        pulse_reg <= 1'b0;
        gap_cnt_reg <= gap_cnt_reg - 32'h0000_0001;
      end
    end
    else
    begin
      pulses_left_reg <= 3'h0;
      pulse_reg <= 1'b0;
    end
  end

  assign pulse_o = pulse_reg;

  // Read view; the manual bit always reads back as zero.
  always_comb
  begin
    watch_view = 16'h0000;
    watch_view[lepc_pkg::LEPC_BIT_ENABLE] = ctrl_reg.energy_watch_enable;
    watch_view[lepc_pkg::LEPC_BIT_AUTO_WAKE] = ctrl_reg.auto_wake_enable;
    watch_view[lepc_pkg::LEPC_BIT_AUTO_SLEEP] = ctrl_reg.auto_sleep_enable;
    watch_view[lepc_pkg::LEPC_BIT_BURST_DIS] = ctrl_reg.pulse_burst_disable;
    watch_view[lepc_pkg::LEPC_BIT_PWR_STATE] = (state_reg == LEPC_ST_UP);
    watch_view[lepc_pkg::LEPC_BIT_ERR_HIT] = err_hit_reg;
    watch_view[lepc_pkg::LEPC_BIT_DATA_HIT] = data_hit_reg;
    watch_view[lepc_pkg::LEPC_ERR_THR_MSB:lepc_pkg::LEPC_ERR_THR_LSB] =
      ctrl_reg.error_event_threshold;
    watch_view[lepc_pkg::LEPC_DATA_THR_MSB:lepc_pkg::LEPC_DATA_THR_LSB] =
      ctrl_reg.data_event_threshold;
  end

  // Read data is registered and holds until the next read.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= 16'h0000;
    end
    else if (req.rd)
    begin
      if (req.addr == lepc_pkg::LEPC_ADDR_ENERGY_WATCH)
      begin
        rdata_reg <= watch_view;
      end
      else if (req.addr == lepc_pkg::LEPC_ADDR_PAGE_SELECT)
      begin
        rdata_reg <= {14'h0000, page_reg};
      end
      else
      begin
        rdata_reg <= 16'h0000;
      end
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule // lepc_line_energy_power_control

// [lepc_line_partner.sv]
// Link partner model: drives energy-detect events and the line energy level.
// Assumes the bench calls its tasks; outputs change only at falling edges.
`timescale 1ns/100ps

module lepc_line_partner (
  // Clock.
  input wire logic clk_sys_i,
  // Line toward the device.
  output logic data_event_o,
  output logic error_event_o,
  output logic line_energy_o
);
  // Quiet line with energy present at start.
  initial
  begin
    data_event_o = 1'b0;
    error_event_o = 1'b0;
    line_energy_o = 1'b1;
  end

  // Sets the energy level seen by the device from the next rising edge.
  task automatic energy(input logic v);
    @(negedge clk_sys_i);
    line_energy_o = v;
  endtask

  // Sends n one-cycle events; a larger gap makes a slow partner.
  task automatic send(input int n, input logic err, input int gap);
    repeat (n)
    begin
      @(negedge clk_sys_i);
      data_event_o = !err;
      error_event_o = err;
      @(negedge clk_sys_i);
      data_event_o = 1'b0;
      error_event_o = 1'b0;
      repeat (gap) @(negedge clk_sys_i);
    end
  endtask
endmodule // lepc_line_partner

// [lepc_pkg.sv]
// Package for the line energy power control block: register map, field
// positions, reset values and timing constants.
// Assumes a 50 MHz system clock and a 5-bit management register address.
package lepc_pkg;

  // Management register addresses.
  localparam logic [4:0] LEPC_ADDR_PAGE_SELECT = 5'h13;
  localparam logic [4:0] LEPC_ADDR_ENERGY_WATCH = 5'h1d;

  // Field positions of energy_watch_control.
  localparam int LEPC_BIT_ENABLE = 15;
  localparam int LEPC_BIT_AUTO_WAKE = 14;
  localparam int LEPC_BIT_AUTO_SLEEP = 13;
  localparam int LEPC_BIT_MANUAL = 12;
  localparam int LEPC_BIT_BURST_DIS = 11;
  localparam int LEPC_BIT_PWR_STATE = 10;
  localparam int LEPC_BIT_ERR_HIT = 9;
  localparam int LEPC_BIT_DATA_HIT = 8;
  localparam int LEPC_ERR_THR_MSB = 7;
  localparam int LEPC_ERR_THR_LSB = 4;
  localparam int LEPC_DATA_THR_MSB = 3;
  localparam int LEPC_DATA_THR_LSB = 0;

  // Reset values.
  localparam logic LEPC_RST_AUTO_WAKE = 1'b1;
  localparam logic LEPC_RST_AUTO_SLEEP = 1'b1;
  localparam logic LEPC_RST_BURST_DIS = 1'b0;
  localparam logic [3:0] LEPC_RST_ERR_THR = 4'h1;
  localparam logic [3:0] LEPC_RST_DATA_THR = 4'h1;
  localparam logic [1:0] LEPC_RST_PAGE = 2'h0;

  // Page select code that opens the link diagnostics page.
  localparam logic [1:0] LEPC_PAGE_DIAG = 2'h2;

  // Pulse burst lengths.
  localparam logic [2:0] LEPC_BURST_LONG = 3'h4;
  localparam logic [2:0] LEPC_BURST_SHORT = 3'h1;

  // Idle time after which event counters restart.
  localparam longint LEPC_CLK_HZ = 50000000;
  localparam longint LEPC_IDLE_SEC = 2;
  localparam longint LEPC_IDLE_CYCLES = LEPC_IDLE_SEC * LEPC_CLK_HZ;

  // Writable control fields of energy_watch_control.
  typedef struct packed {
    logic energy_watch_enable;
    logic auto_wake_enable;
    logic auto_sleep_enable;
    logic pulse_burst_disable;
    logic [3:0] error_event_threshold;
    logic [3:0] data_event_threshold;
  } lepc_ctrl_t;

  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } lepc_req_t;

endpackage

// [tb.sv]
// Bench for the line energy power control block with a register model.
// Assumes the link partner model drives the line-side inputs.
`timescale 1ns/100ps

module tb;
  logic clk_sys_i, rst_n_i, strap_energy_en_i, reg_wr_i, reg_rd_i, data_event_i;
  logic error_event_i, line_energy_i, power_up_o, pulse_o, diag_page_open_o;
  logic [4:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, ctl;
  logic m_en, m_aw, m_as, m_bd, m_pw, m_eh, m_dh;
  logic [3:0] m_et, m_dt;
  int err_count, checks_done, pulses, seed, d, e;

  lepc_line_energy_power_control #(.IDLE_CYCLES(80), .PULSE_GAP(2)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .strap_energy_en_i(strap_energy_en_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .data_event_i(data_event_i),
    .error_event_i(error_event_i), .line_energy_i(line_energy_i),
    .power_up_o(power_up_o), .pulse_o(pulse_o), .diag_page_open_o(diag_page_open_o));
  lepc_line_partner part_u (.clk_sys_i(clk_sys_i), .data_event_o(data_event_i),
    .error_event_o(error_event_i), .line_energy_o(line_energy_i));

  // System clock, 20 ns period.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // Pulses toward the line are counted for the burst checks.
  always @(posedge clk_sys_i)
    if (pulse_o === 1'b1)
      pulses++;

  function automatic logic [15:0] view();
    return {m_en, m_aw, m_as, 1'b0, m_bd, m_pw, m_eh, m_dh, m_et, m_dt};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk_sys_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, v};
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask

  // A read of the control word clears both sticky flags in the model too.
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk_sys_i);
    {reg_rd_i, reg_addr_i} = {1'b1, a};
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    @(negedge clk_sys_i);
    chk(reg_rdata_o, exp);
    if (a == 5'h1d)
      {m_eh, m_dh} = 2'b00;
  endtask

  task automatic set_ctl(input logic [15:0] c);
    wr(5'h1d, c);
    {m_en, m_aw, m_as, m_bd, m_et, m_dt} = {c[15:13], c[11], c[7:0]};
  endtask

  // Bounded wait; running out of cycles ends the run.
  task automatic wait_pwr(input logic v);
    int n;
    for (n = 0; n < 50 && power_up_o !== v; n++)
      @(negedge clk_sys_i);
    chk(16'(power_up_o), 16'(v));
    if (n == 50)
      complete_run();
  endtask

  // Main sequence; reset, page select, auto sleep and wake, then manual toggles.
  initial
  begin
    seed = 52;
    {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 24'h000000;
    strap_energy_en_i = 1'($random(seed));
    d = 2 + ($unsigned($random(seed)) % 14);
    e = 1 + ($unsigned($random(seed)) % 15);
    {m_en, m_aw, m_as, m_bd, m_pw, m_eh, m_dh} = {strap_energy_en_i, 6'b110100};
    {m_et, m_dt} = 8'h11;
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    rd(5'h1d, view());
    rd(5'($unsigned($random(seed)) % 16), 16'h0000);
    wr(5'h13, {14'($random(seed)), 2'b10});
    chk(16'(diag_page_open_o), 16'h0001);
    wr(5'h13, 16'h0001);
    chk(16'(diag_page_open_o), 16'h0000);
    ctl = {8'he0, e[3:0], d[3:0]};
    part_u.energy(1'b0);
    set_ctl(ctl);
    m_pw = 1'b0;
    wait_pwr(1'b0);
    rd(5'h1d, view());
    part_u.energy(1'b1);
    part_u.send(d - 1, 1'b0, 3);
    repeat (100) @(negedge clk_sys_i);
    part_u.send(1, 1'b0, 0);
    rd(5'h1d, view());
    part_u.send(e, 1'b1, 0);
    chk(16'(power_up_o), 16'h0000);
    pulses = 0;
    part_u.send(d - 1, 1'b0, 0);
    {m_pw, m_eh, m_dh} = 3'b111;
    wait_pwr(1'b1);
    repeat (20) @(negedge clk_sys_i);
    chk(16'(pulses), 16'h0004);
    rd(5'h1d, view());
    rd(5'h1d, view());
    ctl[11] = 1'b1;
    part_u.energy(1'b0);
    set_ctl(ctl);
    m_pw = 1'b0;
    wait_pwr(1'b0);
    part_u.energy(1'b1);
    pulses = 0;
    wr(5'h1d, ctl | 16'h1000);
    m_pw = 1'b1;
    wait_pwr(1'b1);
    repeat (20) @(negedge clk_sys_i);
    chk(16'(pulses), 16'h0001);
    wr(5'h1d, ctl);
    chk(16'(power_up_o), 16'h0001);
    rd(5'h1d, view());
    wr(5'h1d, ctl | 16'h1000);
    m_pw = 1'b0;
    wait_pwr(1'b0);
    rd(5'h1d, view());
    complete_run();
  end
endmodule // tb
